// [bench/tpc_ctrl_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module tpc_ctrl_asserts (
	input wire logic	clock_i,
	input wire logic	reset_n_i,
	input wire logic	chip_select_n_i,
	input wire logic	busy_o,
	input wire logic	busy_oe_o,
	input wire logic	data_out_oe_o,
	input wire logic	touch_irq_n_o,
	input wire logic	x_plus_plate_on_o,
	input wire logic	x_minus_plate_on_o,
	input wire logic	y_plus_plate_on_o,
	input wire logic	y_minus_plate_on_o,
	input wire logic	plates_float_o,
	input wire logic	reference_on_o,
	input wire logic	reference_power_bit_o,
	input wire logic	switch_power_bit_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// Six cycles of a steady pin outlast the synchroniser lag
	a_ref_tracks_bit: assert property (reference_on_o == reference_power_bit_o)
		else $error("reference enable differs from its bit");
	a_oe_paired: assert property (busy_oe_o == data_out_oe_o)
		else $error("busy and data enables differ");
	a_oe_in_frame: assert property (!chip_select_n_i [*6] |-> data_out_oe_o && busy_oe_o)
		else $error("outputs not driven in frame");
	a_oe_release: assert property (chip_select_n_i [*6] |-> !data_out_oe_o)
		else $error("data still driven after frame");
	a_idle_plates: assert property (chip_select_n_i [*6] |-> y_minus_plate_on_o
		&& !x_plus_plate_on_o && !x_minus_plate_on_o && !y_plus_plate_on_o)
		else $error("plates wrong while deselected");
	a_busy_width: assert property ($rose(busy_o) |-> busy_o [*7] ##[1:3] !busy_o)
		else $error("busy pulse length wrong");
	a_float_plates: assert property (plates_float_o |-> !x_plus_plate_on_o
		&& !x_minus_plate_on_o && !y_plus_plate_on_o)
		else $error("plate driven while floated");
	a_float_irq: assert property (plates_float_o |-> touch_irq_n_o)
		else $error("interrupt low in power-down");
	a_both_bits_irq: assert property (chip_select_n_i [*6] && reference_power_bit_o
		&& switch_power_bit_o |-> touch_irq_n_o)
		else $error("interrupt low with both bits set");
endmodule
bind tpc_ctrl tpc_ctrl_asserts u_chk (.*);
`default_nettype wire

// [bench/tpc_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tpc_ctrl_tb;
	import tpc_pkg::*;
	logic				clock_i = 1'b0;
	logic				reset_n_i = 1'b0;
	logic				touch_n = 1'b1;
	logic [RES_W-1:0]	adc = 12'ha5c;
	wire logic			cs_n, sclk, sdi, dout, busy, xp, xn, yp, yn, flt;
	wire logic			refon, adcon, res, sdsel, refb, swb, irq;
	wire logic [2:0]	chan;
	int					bad_count = 0;
	int					check_count = 0;
	int					cycles = 0;
	always #2 clock_i = ~clock_i;
	tpc_ctrl dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
		.serial_clock_i(sclk), .serial_in_i(sdi), .touch_sense_n_i(touch_n),
		.adc_result_i(adc), .data_out_o(dout), .data_out_oe_o(), .busy_o(busy),
		.busy_oe_o(), .touch_irq_n_o(irq), .x_plus_plate_on_o(xp), .x_minus_plate_on_o(xn),
		.y_plus_plate_on_o(yp), .y_minus_plate_on_o(yn), .plates_float_o(flt),
		.reference_on_o(refon), .adc_on_o(adcon), .adc_sample_o(), .channel_select_o(chan),
		.resolution_o(res), .single_or_diff_select_o(sdsel),
		.reference_power_bit_o(refb), .switch_power_bit_o(swb));
	tpc_host host (.clock_i(clock_i), .dout_i(dout), .busy_i(busy), .mon_i(xp | yp),
		.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] cmd(input logic [2:0] ch, input logic m, input logic s,
		input logic r, input logic w);
		return {1'b1, ch, m, s, r, w};
	endfunction
	task automatic go(input logic [7:0] c, input int k);
		host.frame({c, 56'h0} >> k, 24 + k);
	endtask
	task automatic t_modes();
		int pm[4] = '{0, 2, 1, 3};
		logic [1:0] p;
		for (int i = 0; i < 4; i++) begin
			p = pm[i][1:0];
			go(cmd(CH_X_AXIS, 1'b0, 1'b1, p[1], p[0]), 0);
			check("data", host.rx, {9'h0, adc, 3'h0});
			check("busy", host.bx, 24'h008000);
			check("refbit", refb, p[1]);
			check("swbit", swb, p[0]);
			check("chan", chan, CH_X_AXIS);
			check("refon", refon, p[1]);
			if (!p[0]) begin
				check("adcoff", adcon, 1'b0);
				check("track", host.mx, 24'h070000);
			end
		end
		$display("test modes done");
	endtask
	task automatic t_lead();
		go(cmd(CH_Y_AXIS, 1'b1, 1'b0, 1'b0, 1'b0), 3);
		check("data8", host.rx, {9'h0, adc[11:4], 7'h0});
		check("res", res, 1'b1);
		check("sersel", sdsel, 1'b0);
		// Old switch bit one keeps the axis plate on from rising five until rising eight
		check("diff", host.mx, 24'h0ffff0);
		$display("test lead done");
	endtask
	task automatic t_hold();
		go(cmd(CH_Y_AXIS, 1'b0, 1'b1, 1'b0, 1'b1), 0);
		go(cmd(CH_Y_AXIS, 1'b0, 1'b1, 1'b0, 1'b1), 0);
		check("hold", host.mx[17:0], 18'h3ffff);
		$display("test hold done");
	endtask
	task automatic t_overlap();
		logic [7:0] c;
		c = cmd(CH_X_AXIS, 1'b0, 1'b1, 1'b0, 1'b0);
		host.frame({c, 7'h0, c, 41'h0}, 39);
		check("data2", host.rx, {9'h0, adc, 3'h0, adc, 3'h0});
		check("busy2", host.bx, 39'h0040008000);
		$display("test overlap done");
	endtask
	task automatic t_powerdown();
		host.idle_sdi = 1'b1;
		touch_n = 1'b0;
		go(cmd(CH_Z1, 1'b0, 1'b1, 1'b1, 1'b1), 0);
		check("float", flt, 1'b1);
		check("cleared", chan, 3'h0);
		check("irqpd", irq, 1'b1);
		host.idle_sdi = 1'b0;
		go(cmd(CH_Z1, 1'b0, 1'b1, 1'b1, 1'b1), 0);
		check("float0", flt, 1'b0);
		check("irq11", irq, 1'b1);
		touch_n = 1'b1;
		$display("test powerdown done");
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		#1 reset_n_i = 1'b1;
		repeat (8) @(posedge clock_i);
		t_modes();
		t_lead();
		t_hold();
		t_overlap();
		t_powerdown();
		summarize();
	end
endmodule
`default_nettype wire

// [bench/tpc_host.sv]
`timescale 1ns/10ps
`default_nettype none
module tpc_host (
	input wire logic	clock_i,
	input wire logic	dout_i,
	input wire logic	busy_i,
	input wire logic	mon_i,
	output logic		cs_n_o,
	output logic		sclk_o,
	output logic		sdi_o
);
	logic [63:0]	rx;
	logic [63:0]	bx;
	logic [63:0]	mx;
	logic			idle_sdi;
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		idle_sdi = 1'b0;
	end
	// Sampling at the falling edge avoids racing the device's output lag
	task automatic frame(input logic [63:0] b, input int n);
		@(posedge clock_i);
		#1;
		rx = '0;
		bx = '0;
		mx = '0;
		cs_n_o = 1'b0;
		#64;
		for (int i = 0; i < n; i++) begin
			sdi_o = b[63-i];
			#16 sclk_o = 1'b1;
			#16 rx = {rx[62:0], dout_i};
			bx = {bx[62:0], busy_i};
			mx = {mx[62:0], mon_i};
			sclk_o = 1'b0;
		end
		#64 cs_n_o = 1'b1;
		sdi_o = idle_sdi;
		#96;
	endtask
endmodule
`default_nettype wire

// [rtl/tpc_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module tpc_ctrl (
	input  wire logic                    clock_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    chip_select_n_i,
	input  wire logic                    serial_clock_i,
	input  wire logic                    serial_in_i,
	input  wire logic                    touch_sense_n_i,
	input  wire logic [tpc_pkg::RES_W-1:0] adc_result_i,
	output logic                         data_out_o,
	output logic                         data_out_oe_o,
	output logic                         busy_o,
	output logic                         busy_oe_o,
	output logic                         touch_irq_n_o,
	output logic                         x_plus_plate_on_o,
	output logic                         x_minus_plate_on_o,
	output logic                         y_plus_plate_on_o,
	output logic                         y_minus_plate_on_o,
	output logic                         plates_float_o,
	output logic                         reference_on_o,
	output logic                         adc_on_o,
	output logic                         adc_sample_o,
	output logic [2:0]                   channel_select_o,
	output logic                         resolution_o,
	output logic                         single_or_diff_select_o,
	output logic                         reference_power_bit_o,
	output logic                         switch_power_bit_o
);
	import tpc_pkg::*;

	logic rst_s1_q;
	logic rst_n;
	logic [1:0] cs_s_q;
	logic [1:0] sck_s_q;
	logic [1:0] din_s_q;
	logic [1:0] pen_s_q;
	logic cs_prev_q;
	logic sck_prev_q;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// Pins are asynchronous; only the second stage is ever read
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cs_s_q     <= 2'h3;
			sck_s_q    <= 2'h0;
			din_s_q    <= 2'h0;
			pen_s_q    <= 2'h3;
			cs_prev_q  <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			cs_s_q     <= {cs_s_q[0], chip_select_n_i};
			sck_s_q    <= {sck_s_q[0], serial_clock_i};
			din_s_q    <= {din_s_q[0], serial_in_i};
			pen_s_q    <= {pen_s_q[0], touch_sense_n_i};
			cs_prev_q  <= cs_s_q[1];
			sck_prev_q <= sck_s_q[1];
		end
	end

	logic cs_n;
	logic din;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	assign cs_n     = cs_s_q[1];
	assign din      = din_s_q[1];
	assign sck_rise = sck_s_q[1] & ~sck_prev_q;
	assign sck_fall = ~sck_s_q[1] & sck_prev_q;
	assign cs_fall  = ~cs_n & cs_prev_q;
	assign cs_rise  = cs_n & ~cs_prev_q;

	// Frame and command state
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CMD_W-1:0] shift_q, shift_d;
	logic [2:0]       chan_q, chan_d;
	logic             mode_q, mode_d;
	logic             ser_q, ser_d;
	logic             pd1_q, pd1_d;
	logic             pd0_q, pd0_d;
	logic             oe_q, oe_d;
	logic             busy_q, busy_d;
	logic             dout_q, dout_d;
	logic [RES_W-1:0] res_q, res_d;
	logic [3:0]       left_q, left_d;
	logic             sample_q, sample_d;
	logic             full_pd;

	// Serial input high with chip select high is the full power-down request
	assign full_pd = cs_n & din;

	always_comb begin
		cnt_d    = cnt_q;
		shift_d  = shift_q;
		chan_d   = chan_q;
		mode_d   = mode_q;
		ser_d    = ser_q;
		pd1_d    = pd1_q;
		pd0_d    = pd0_q;
		oe_d     = oe_q;
		busy_d   = busy_q;
		dout_d   = dout_q;
		res_d    = res_q;
		left_d   = left_q;
		sample_d = 1'b0;
		if (cs_n) begin
			cnt_d  = CNT_RESET;
			oe_d   = 1'b0;
			busy_d = 1'b0;
			dout_d = 1'b0;
			left_d = 4'h0;
			if (full_pd) begin
				shift_d = CMD_RESET;
				chan_d  = CMD_RESET[POS_CHAN_HI:POS_CHAN_LO];
				mode_d  = CMD_RESET[POS_MODE];
				ser_d   = CMD_RESET[POS_SER];
				pd1_d   = CMD_RESET[POS_REF];
				pd0_d   = CMD_RESET[POS_SW];
			end
		end else begin
			if (cs_fall) begin
				oe_d   = 1'b1;
				busy_d = 1'b0;
				dout_d = 1'b0;
			end
			if (sck_rise) begin
				// A high start bit opens decoding; idle or past the quiet
				// clocks, so a new command may overlap the old result
				// The clock after the fifteenth may already carry a new start bit
				if ((cnt_q == CNT_RESET || cnt_q >= EDGE_NEXT - 5'h01) && din) begin
					cnt_d   = 5'h01;
					shift_d = {shift_q[CMD_W-2:0], din};
				end else if (cnt_q != CNT_RESET) begin
					if (cnt_q != EDGE_MAX)
						cnt_d = cnt_q + 5'h01;
					if (cnt_q < EDGE_SW)
						shift_d = {shift_q[CMD_W-2:0], din};
					unique case (cnt_q + 5'h01)
						EDGE_CHAN: chan_d = {shift_q[1:0], din};
						EDGE_MODE: mode_d = din;
						EDGE_SER:  ser_d  = din;
						EDGE_REF:  pd1_d  = din;
						EDGE_SW:   pd0_d  = din;
						default: ;
					endcase
				end
			end
			if (sck_fall) begin
				if (left_q != 4'h0) begin
					dout_d = res_q[RES_W-1];
					res_d  = {res_q[RES_W-2:0], 1'b0};
					left_d = left_q - 4'h1;
				end else begin
					dout_d = 1'b0;
				end
				if (cnt_q == EDGE_BUSY) begin
					busy_d   = 1'b1;
					sample_d = 1'b1;
				end else begin
					busy_d = 1'b0;
				end
				if (cnt_q == EDGE_OUT) begin
					// 8-bit results are the upper bits of the converter word
					dout_d = adc_result_i[RES_W-1];
					res_d  = {adc_result_i[RES_W-2:0], 1'b0};
					left_d = (mode_q ? LEN_8 : LEN_12) - 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q    <= CNT_RESET;
			shift_q  <= CMD_RESET;
			chan_q   <= CMD_RESET[POS_CHAN_HI:POS_CHAN_LO];
			mode_q   <= CMD_RESET[POS_MODE];
			ser_q    <= CMD_RESET[POS_SER];
			pd1_q    <= CMD_RESET[POS_REF];
			pd0_q    <= CMD_RESET[POS_SW];
			oe_q     <= 1'b0;
			busy_q   <= 1'b0;
			dout_q   <= 1'b0;
			res_q    <= '0;
			left_q   <= 4'h0;
			sample_q <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			shift_q  <= shift_d;
			chan_q   <= chan_d;
			mode_q   <= mode_d;
			ser_q    <= ser_d;
			pd1_q    <= pd1_d;
			pd0_q    <= pd0_d;
			oe_q     <= oe_d;
			busy_q   <= busy_d;
			dout_q   <= dout_d;
			res_q    <= res_d;
			left_q   <= left_d;
			sample_q <= sample_d;
		end
	end

	// Window flags: cnt_q at a falling edge equals that edge's ordinal
	logic trk_q, trk_d;
	logic conv_q, conv_d;
	logic [3:0] sw_q, sw_d; // {xp, xn, yp, yn}
	logic [3:0] chan_sw;
	logic       axis_sel;
	logic       plate_sel;
	logic       irq_n_q, irq_n_d;
	logic       adc_on_q, adc_on_d;
	logic       float_q, float_d;

	always_comb begin
		unique case (chan_q)
			CH_Y_AXIS: chan_sw = 4'h3;
			CH_Z1:     chan_sw = 4'h6;
			CH_Z2:     chan_sw = 4'h6;
			CH_X_AXIS: chan_sw = 4'hc;
			default:   chan_sw = 4'h0;
		endcase
	end

	assign axis_sel  = (chan_q == CH_X_AXIS) || (chan_q == CH_Y_AXIS);
	assign plate_sel = chan_sw != 4'h0;

	always_comb begin
		trk_d    = trk_q;
		conv_d   = conv_q;
		sw_d     = sw_q;
		float_d  = 1'b0;
		if (cs_n) begin
			trk_d  = 1'b0;
			conv_d = 1'b0;
		end else if (sck_fall) begin
			if (cnt_q == EDGE_TRK) begin
				trk_d  = 1'b1;
				conv_d = 1'b1;
			end else if (cnt_q == EDGE_BUSY) begin
				trk_d = 1'b0;
			end
			if (cnt_q == EDGE_LAST)
				conv_d = 1'b0;
		end
		if (cs_n) begin
			sw_d    = 4'h1;
			float_d = full_pd;
		end else if (pd0_q && cnt_q < EDGE_HOLD) begin
			sw_d = sw_q;
		end else if (pd0_q && axis_sel) begin
			sw_d = chan_sw;
		end else if (!ser_q && plate_sel) begin
			sw_d = conv_q ? chan_sw : 4'h0;
		end else begin
			sw_d = trk_q ? chan_sw : 4'h0;
		end
		// ADC power with the switch bit set follows the reference bit or the frame, else the conversion span
		if (pd0_q)
			adc_on_d = pd1_q | ~cs_n;
		else
			adc_on_d = conv_q;
		// Pen detect is masked during tracking and conversion
		if (cs_n)
			irq_n_d = (pd1_q & pd0_q) | full_pd | pen_s_q[1];
		else
			irq_n_d = conv_q | pen_s_q[1];
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			trk_q    <= 1'b0;
			conv_q   <= 1'b0;
			sw_q     <= 4'h1;
			float_q  <= 1'b0;
			adc_on_q <= 1'b0;
			irq_n_q  <= 1'b1;
		end else begin
			trk_q    <= trk_d;
			conv_q   <= conv_d;
			sw_q     <= sw_d;
			float_q  <= float_d;
			adc_on_q <= adc_on_d;
			irq_n_q  <= irq_n_d;
		end
	end

	assign data_out_o              = dout_q;
	assign data_out_oe_o           = oe_q;
	assign busy_o                  = busy_q;
	assign busy_oe_o               = oe_q;
	assign touch_irq_n_o           = irq_n_q;
	assign x_plus_plate_on_o       = sw_q[3];
	assign x_minus_plate_on_o      = sw_q[2];
	assign y_plus_plate_on_o       = sw_q[1];
	assign y_minus_plate_on_o      = sw_q[0];
	assign plates_float_o          = float_q;
	assign reference_on_o          = pd1_q;
	assign adc_on_o                = adc_on_q;
	assign adc_sample_o            = sample_q;
	assign channel_select_o        = chan_q;
	assign resolution_o            = mode_q;
	assign single_or_diff_select_o = ser_q;
	assign reference_power_bit_o   = pd1_q;
	assign switch_power_bit_o      = pd0_q;
endmodule
`default_nettype wire

// [rtl/tpc_pkg.sv]
package tpc_pkg;
	localparam int CMD_W      = 8;
	localparam int RES_W      = 12;
	localparam int CNT_W      = 5;
	// Serial clock ordinals within a frame
	localparam logic [4:0] EDGE_CHAN  = 5'h04;
	localparam logic [4:0] EDGE_MODE  = 5'h05;
	localparam logic [4:0] EDGE_SER   = 5'h06;
	localparam logic [4:0] EDGE_REF   = 5'h07;
	localparam logic [4:0] EDGE_SW    = 5'h08;
	localparam logic [4:0] EDGE_TRK   = 5'h05;
	localparam logic [4:0] EDGE_HOLD  = 5'h05;
	localparam logic [4:0] EDGE_BUSY  = 5'h08;
	localparam logic [4:0] EDGE_OUT   = 5'h09;
	localparam logic [4:0] EDGE_LAST  = 5'h14;
	localparam logic [4:0] EDGE_NEXT  = 5'h10;
	localparam logic [4:0] EDGE_MAX   = 5'h1f;
	// Result lengths
	localparam logic [3:0] LEN_12     = 4'hc;
	localparam logic [3:0] LEN_8      = 4'h8;
	// Command byte field positions
	localparam int POS_START   = 7;
	localparam int POS_CHAN_HI = 6;
	localparam int POS_CHAN_LO = 4;
	localparam int POS_MODE    = 3;
	localparam int POS_SER     = 2;
	localparam int POS_REF     = 1;
	localparam int POS_SW      = 0;
	// Channel codes that drive the plates
	localparam logic [2:0] CH_Y_AXIS  = 3'h1;
	localparam logic [2:0] CH_Z1      = 3'h3;
	localparam logic [2:0] CH_Z2      = 3'h4;
	localparam logic [2:0] CH_X_AXIS  = 3'h5;
	// Reset values
	localparam logic [7:0] CMD_RESET  = 8'h00;
	localparam logic [4:0] CNT_RESET  = 5'h00;
endpackage
